/* design/tfl_regs.svh */
// constants for the transceiver fault and signal-lost status block
// assumes a single 200 MHz clock and a byte-wide management register port
//
// Contract
// R1: out-of-range laser power latches fault, laser off
// R2: fault pin low normally, high on fault
// R3: fault stays latched after the cause goes
// R4: fault clears by disable toggle or power cycle
// R5: fault state mirrored in status byte bit 2
// R6: watch incoming signal transitions for modulation
// R7: signal-lost pin high when no modulation
// R8: signal-lost state mirrored in status bit 1
// R9: host ties disable input low if unused
// R10: eye-safety monitor turns transmitter off
// R11: disable input high turns optics off
// R12: software disable bit ORed with disable pin
// R13: status bit 7 reflects disable pin level
// R14: software disable bit resets to enabled
// R15: toggle is disable high then low
`ifndef TFL_REGS_SVH
`define TFL_REGS_SVH
`define TFL_CSB_OFFSET 8'h6e
`define TFL_CSB_RESET 8'h00
`define TFL_BIT_PIN_DIS 7
`define TFL_BIT_SW_DIS 6
`define TFL_BIT_FAULT 2
`define TFL_BIT_LOST 1
// time without any receive transition before signal is declared lost
`define TFL_LOS_TIME_NS 1000
`define TFL_LOS_CYCLES (`TFL_LOS_TIME_NS / 5)
`endif

/* design/tfl_pkg.sv */
// types for the transceiver fault and signal-lost status block
// assumes tfl_regs.svh supplies all numeric constants
package tfl_pkg;
   // management byte access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tfl_req_t;
   // analog monitor flags from the optical front end
   typedef struct packed {
      logic pwr_low;
      logic pwr_high;
      logic eye_unsafe;
   } tfl_mon_t;
   typedef enum logic [1:0] {TFL_RUN, TFL_FAULT, TFL_WAIT_LOW} tfl_state_t;
endpackage : tfl_pkg

/* design/tfl_sync3.sv */
// three-flop synchroniser with agreement filter
// assumes an asynchronous pin input and a free running clock
`timescale 1ns/1ps
`default_nettype none
module tfl_sync3 (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic din,
   output logic dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // second and third stages must agree before the level moves
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         dout <= 1'b0;
      end else if (ce) begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            dout <= s3_q;
         end
      end
   end
endmodule : tfl_sync3
`default_nettype wire

/* design/tfl_status.sv */
// laser fault latch, receive signal-lost detector and status byte
// assumes monitor flags and pins are asynchronous; register port is synchronous
`timescale 1ns/1ps
`default_nettype none
`include "tfl_regs.svh"
module tfl_status (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic tx_disable_pin,
   input wire tfl_pkg::tfl_mon_t mon,
   input wire logic rx_edge,
   input wire tfl_pkg::tfl_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic laser_on,
   output logic tx_fault_o,
   output logic tx_fault_oe,
   output logic receive_signal_lost_pin,
   output logic receive_signal_lost
);
   import tfl_pkg::*;

   logic dis_s;
   logic low_s;
   logic high_s;
   logic eye_s;
   logic edge_s;
   logic sw_dis_q;
   logic fault_q;
   tfl_state_t st_q;
   tfl_state_t st_d;
   logic [15:0] los_cnt_q;
   logic edge_prev_q;
   logic edge_seen;
   logic los_d;
   logic bad_power;
   logic dis_any;
   logic hit;
   logic [7:0] csb;

   // pin and monitor inputs all cross through the same filter
   logic [4:0] raw;
   logic [4:0] syn;
   // the disable pin enters inverted: the filter resets to zero, and that zero
   // must read as disabled, the same as the pull-up holds an open pin, so the
   // laser cannot flash on while the filter fills after reset
   assign raw = {!tx_disable_pin, mon.pwr_low, mon.pwr_high, mon.eye_unsafe, rx_edge};
   generate
      for (genvar i = 0; i < 5; i++) begin : g_sync
         tfl_sync3 u_sync (
            .mclk(mclk),
            .rstn(rstn),
            .ce(ce),
            .din(raw[i]),
            .dout(syn[i])
         );
      end
   endgenerate
   assign dis_s = !syn[4]; // R11
   assign low_s = syn[3];
   assign high_s = syn[2];
   assign eye_s = syn[1];
   assign edge_s = syn[0];

   // the status byte is the only address this block decodes; reads of any other address still answer, with zero
   function automatic logic csb_addr(input logic [7:0] a);
      return (a == `TFL_CSB_OFFSET);
   endfunction : csb_addr

   // qualified strobes of the register port
   logic rd_hit;
   logic wr_hit;
   assign rd_hit = req.rd & csb_addr(req.addr);
   assign wr_hit = req.wr & hit;

   // fault causes and disable combination
   assign bad_power = low_s | high_s | eye_s; // R1 R10
   assign dis_any = dis_s | sw_dis_q; // R11 R12
   assign hit = csb_addr(req.addr);
   assign edge_seen = edge_s ^ edge_prev_q; // R6

   // fault state machine: latch, wait for disable high, then low
   always_comb begin
      st_d = st_q;
      case (st_q)
         TFL_RUN: begin
            if (bad_power) st_d = TFL_FAULT; // R1
         end
         TFL_FAULT: begin
            if (dis_s) st_d = TFL_WAIT_LOW; // R3 R4 R15
         end
         TFL_WAIT_LOW: begin
            if (!dis_s) st_d = bad_power ? TFL_FAULT : TFL_RUN; // R15
         end
         default: st_d = TFL_FAULT;
      endcase
   end

   // inactivity counter for the receive transition detector
   assign los_d = (los_cnt_q >= 16'(`TFL_LOS_CYCLES - 1)); // R7

   // status byte view
   always_comb begin
      csb = `TFL_CSB_RESET;
      csb[`TFL_BIT_PIN_DIS] = dis_s; // R13
      csb[`TFL_BIT_SW_DIS] = sw_dis_q; // R12
      csb[`TFL_BIT_FAULT] = fault_q; // R5
      csb[`TFL_BIT_LOST] = receive_signal_lost; // R8
   end

   // timing seen from the pins: a monitor flag or pin change needs about four
   // clocks through its filter, then one more to reach the registered outputs.
   // glitches shorter than two clocks never agree in the filter and are lost,
   // which is the intent for the slow status pins but means the receive
   // transition detector must hold each level for at least that long.
   // every register below freezes while the clock enable is low.

   // next values of the registered outputs, kept as named wires
   logic fault_d;
   logic oe_d;
   logic laser_d;
   logic lost_d;
   logic sw_dis_d;
   logic [15:0] los_cnt_d;
   logic [7:0] rdata_d;

   // fault flag and open-drain enable: drive low while healthy, release on fault
   assign fault_d = (st_d != TFL_RUN); // R3
   assign oe_d = (st_d == TFL_RUN); // R2

   // laser enable: no fault, no disable source and no bad monitor flag
   // bad_power is looked at directly so the laser goes dark in the same cycle
   // that the fault is taken, not one state later
   assign laser_d = (st_d == TFL_RUN) & !dis_any & !bad_power; // R1 R10 R11

   // transition timer: cleared by a seen change, saturates at the timeout
   assign los_cnt_d = edge_seen ? 16'h0000 : (los_d ? los_cnt_q : los_cnt_q + 16'h0001);
   assign lost_d = los_d & !edge_seen; // R7

   // register port: only the software disable bit is writable
   assign sw_dis_d = wr_hit ? req.wdata[`TFL_BIT_SW_DIS] : sw_dis_q; // R12
   assign rdata_d = rd_hit ? csb : 8'h00;

   // fault state register and its status copy
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_q <= TFL_RUN;
         fault_q <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         fault_q <= fault_d; // R5
      end
   end

   // fault pin: high level flag plus open-drain enable
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tx_fault_o <= 1'b0;
         tx_fault_oe <= 1'b1;
      end else if (ce) begin
         tx_fault_o <= fault_d; // R2
         tx_fault_oe <= oe_d; // R2
      end
   end

   // laser drive, dark through reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         laser_on <= 1'b0;
      end else if (ce) begin
         laser_on <= laser_d; // R1 R10 R11
      end
   end

   // transition timer, starts saturated so the link reads as lost from reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         los_cnt_q <= 16'(`TFL_LOS_CYCLES - 1);
         edge_prev_q <= 1'b0;
      end else if (ce) begin
         los_cnt_q <= los_cnt_d; // R6
         edge_prev_q <= edge_s;
      end
   end

   // signal-lost status and its pin copy
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         receive_signal_lost <= 1'b1;
         receive_signal_lost_pin <= 1'b1;
      end else if (ce) begin
         receive_signal_lost <= lost_d; // R7
         receive_signal_lost_pin <= lost_d; // R7
      end
   end

   // software disable bit, enabled again by every power cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sw_dis_q <= 1'b0; // R14
      end else if (ce) begin
         sw_dis_q <= sw_dis_d; // R12
      end
   end

   // read answer one cycle after the strobe; other addresses read zero
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end else if (ce) begin
         rdata <= rdata_d;
         rvalid <= req.rd;
      end
   end
endmodule : tfl_status
`default_nettype wire

/* tb/tfl_props.sv */
// checker on the status block ports
// assumes one clock with an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module tfl_props (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic tx_disable_pin,
   input wire tfl_pkg::tfl_mon_t mon,
   input wire tfl_pkg::tfl_req_t req,
   input wire logic [7:0] rdata,
   input wire logic laser_on,
   input wire logic tx_fault_o,
   input wire logic receive_signal_lost_pin,
   input wire logic receive_signal_lost
);
   logic [3:0] low_q;
   wire logic rd_csb = req.rd && req.addr == 8'h6e;
   // cycles the disable pin has stayed low, saturating
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) low_q <= '0;
      else low_q <= tx_disable_pin ? 4'h0 : low_q + 4'(low_q != 4'hf);
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_fault_dark: assert property (tx_fault_o |-> !laser_on) else $error("lit in fault");
   a_power_bad: assert property ((mon.pwr_low || mon.pwr_high)[*8] |-> tx_fault_o)
      else $error("no fault");
   a_fault_held: assert property (tx_fault_o && low_q > 4'd10 |=> tx_fault_o)
      else $error("fault lost");
   a_eye_off: assert property (mon.eye_unsafe[*8] |-> !laser_on) else $error("eye lit");
   a_pin_off: assert property (tx_disable_pin[*8] |-> !laser_on) else $error("pin lit");
   a_fault_bit: assert property (rd_csb |=> rdata[2] == $past(tx_fault_o))
      else $error("bit 2");
   a_lost_bit: assert property (rd_csb |=> rdata[1] == $past(receive_signal_lost))
      else $error("bit 1");
   a_lost_pin: assert property (receive_signal_lost_pin == receive_signal_lost)
      else $error("lost pin");
   c_fault: cover property (rd_csb && tx_fault_o);
   c_lost: cover property ($rose(receive_signal_lost));
   c_clear: cover property ($fell(tx_fault_o));
endmodule : tfl_props
`default_nettype wire

/* tb/tfl_host.sv */
// host board: drives the disable pin low or drives it high
// assumes the module pull-up holds a released pin high
`timescale 1ns/1ps
`default_nettype none
module tfl_host (
   input wire logic drive_low,
   output logic tx_disable_pin
);
   assign tx_disable_pin = drive_low ? 1'b0 : 1'b1;
endmodule : tfl_host
`default_nettype wire

/* tb/transceiver_fault_los_status_tb.sv */
// bench for the fault and signal-lost status block
// assumes tfl_host drives the disable pin and tfl_props is bound
`timescale 1ns/1ps
`default_nettype none
module transceiver_fault_los_status_tb;
   import tfl_pkg::*;
   logic mclk = 0, rstn = 0, rx_edge = 0, drv = 1, pin, laser_on, fault, lost;
   logic ce = 1, valid, oe;
   tfl_mon_t mon = '0;
   tfl_req_t req = '0;
   logic [7:0] rdata;
   int mismatches, comparisons;
   tfl_host H (.drive_low(drv), .tx_disable_pin(pin));
   tfl_status DUT (.mclk(mclk), .rstn(rstn), .ce(ce), .tx_disable_pin(pin), .mon(mon),
      .rx_edge(rx_edge), .req(req), .rdata(rdata), .rvalid(valid), .laser_on(laser_on),
      .tx_fault_o(fault), .tx_fault_oe(oe), .receive_signal_lost_pin(),
      .receive_signal_lost(lost));
   function automatic logic [7:0] st(logic p, s, f, l);
      return {p, s, 3'b000, f, l, 1'b0};
   endfunction : st
   task automatic cyc(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic chk(string n, logic [7:0] e, g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // one byte access, read data taken the cycle after the strobe
   task automatic acc(logic w, logic [7:0] a, d, e);
      req = {!w, w, a, d};
      cyc(1);
      req = '0;
      if (!w) chk("byte", e, rdata);
      if (!w) chk("valid", 1, valid);
      cyc(1);
   endtask : acc
   task automatic summarize;
      $display("%0d mismatches of %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   initial forever #2.5 mclk = ~mclk;
   initial begin
      #10000;
      mismatches++;
      summarize;
   end
   initial begin
      void'($urandom(32'hd505));
      cyc(8);
      rstn = 1;
      cyc(4);
      acc(0, 8'h6e, 0, st(0, 0, 0, 1));
      acc(1, 8'h6e, 8'h40, 0);
      chk("laser", 0, laser_on);
      acc(0, 8'h6e, 0, st(0, 1, 0, 1));
      acc(1, 8'h6e, 0, 0);
      drv = 0;
      cyc(8);
      acc(0, 8'h6e, 0, st(1, 0, 0, 1));
      chk("laser", 0, laser_on);
      drv = 1;
      acc(0, 8'($urandom_range(8'h6d)), 0, 0);
      $display("control test done");
      repeat (20) begin
         rx_edge = ~rx_edge;
         cyc($urandom_range(4, 20));
      end
      cyc(6);
      acc(0, 8'h6e, 0, st(0, 0, 0, 0));
      cyc(140);
      chk("lost", 0, lost);
      cyc(70);
      chk("lost", 1, lost);
      $display("signal-lost test done");
      mon = 3'b010 << $urandom_range(1);
      cyc(10);
      mon = '0;
      cyc(20);
      acc(0, 8'h6e, 0, st(0, 0, 1, 1));
      chk("fault", 1, fault);
      chk("fault oe", 0, oe);
      drv = 0;
      cyc(10);
      drv = 1;
      cyc(10);
      chk("fault", 0, fault);
      chk("fault oe", 1, oe);
      chk("laser", 1, laser_on);
      mon = 3'b001;
      cyc(10);
      chk("laser", 0, laser_on);
      mon = '0;
      acc(1, 8'h6e, 8'h40, 0);
      rstn = 0;
      cyc(2);
      rstn = 1;
      cyc(4);
      acc(0, 8'h6e, 0, st(0, 0, 0, 1));
      ce = 0;
      acc(1, 8'h6e, 8'h40, 0);
      ce = 1;
      acc(0, 8'h6e, 0, st(0, 0, 0, 1));
      $display("fault test done");
      summarize;
   end
endmodule : transceiver_fault_los_status_tb
bind tfl_status tfl_props P (.*);
`default_nettype wire
